// *** src/gpa_regs.sv ***
// Gain and sample clock phase adjust register bank behind an AXI4-Lite slave
//
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
module gpa_regs (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic              clk_en,        // Low freezes all state outside reset; reset still loads power-on values
    input  wire logic [5:0]        s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [5:0]        s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    output var gpa_pkg::gpa_cfg_t  cfg,           // Live settings to converter core
    output logic                   gain_update    // Pulse: gain changed, no calibration
);
    // Register contents
    gpa_pkg::gpa_cfg_t  next_cfg;
    logic               next_gain_update;
    // Write channel capture
    logic               aw_held,   next_aw_held;
    logic               w_held,    next_w_held;
    logic [3:0]         aw_idx,    next_aw_idx;
    logic [31:0]        w_data,    next_w_data;
    logic [3:0]         w_strb,    next_w_strb;
    logic               next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
    logic [1:0]         next_bresp, next_rresp;
    logic [31:0]        next_rdata;
    logic               range_warn, next_range_warn; // Gain outside advised window
    localparam int      ADJ_W = 9;                   // Width of gain and fine fields

    // Word index from byte address
    function automatic logic [3:0] word_idx(input logic [5:0] a);
        word_idx = a[5:2];
    endfunction : word_idx

    // Mapped register check
    function automatic logic mapped(input logic [3:0] i);
        mapped = (i == gpa_pkg::IDX_GAIN) || (i == gpa_pkg::IDX_FINE) || (i == gpa_pkg::IDX_COARSE)
              || (i == gpa_pkg::IDX_TRIM) || (i == gpa_pkg::IDX_STATUS);
    endfunction : mapped

    // Read view; unused low bits of gain, fine and coarse read as ones, as software writes them
    function automatic logic [31:0] read_word(input logic [3:0] i, input gpa_pkg::gpa_cfg_t c,
                                              input logic w);
        read_word = 32'h0000_0000;
        case (i)
            gpa_pkg::IDX_GAIN:   read_word = {16'h0000, c.gain, 7'h7f};
            gpa_pkg::IDX_FINE:   read_word = {16'h0000, c.fine_phase, 7'h7f};
            gpa_pkg::IDX_COARSE: read_word = {16'h0000, c.phase_adjust_enable, c.coarse_phase_magnitude,
                                              c.low_freq_sample_clock, 10'h3ff};
            gpa_pkg::IDX_TRIM:   read_word = {18'h00000, c.termination_trim_disable, 13'h0000};
            // Status: enable set without trim disable, gain beyond advised window
            gpa_pkg::IDX_STATUS: read_word = {30'h0, w,
                                              c.phase_adjust_enable & ~c.termination_trim_disable};
            default:             read_word = 32'h0000_0000;
        endcase
    endfunction : read_word

    // Next-state logic for bus and registers
    always_comb begin
        next_cfg         = cfg;
        next_gain_update = 1'b0;
        next_aw_held     = aw_held;
        next_w_held      = w_held;
        next_aw_idx      = aw_idx;
        next_w_data      = w_data;
        next_w_strb      = w_strb;
        next_awready     = s_axi_awready;
        next_wready      = s_axi_wready;
        next_bvalid      = s_axi_bvalid;
        next_bresp       = s_axi_bresp;
        next_arready     = s_axi_arready;
        next_rvalid      = s_axi_rvalid;
        next_rresp       = s_axi_rresp;
        next_rdata       = s_axi_rdata;
        next_range_warn  = range_warn;
        // Address and data accepted in either order
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_held = 1'b1;
            next_aw_idx  = word_idx(s_axi_awaddr);
            next_awready = 1'b0;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
            next_wready = 1'b0;
        end
        // Both halves present: commit and respond
        if (aw_held && w_held && !s_axi_bvalid) begin
            next_aw_held = 1'b0;
            next_w_held  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = mapped(aw_idx) ? gpa_pkg::RESP_OKAY : gpa_pkg::RESP_SLVERR;
            // Only the low two lanes carry register bits
            case (aw_idx)
                gpa_pkg::IDX_GAIN: begin
                    if (w_strb[1] && w_strb[0]) begin
                        next_cfg.gain    = w_data[ADJ_W-1+gpa_pkg::ADJ_LSB:gpa_pkg::ADJ_LSB];
                        next_gain_update = 1'b1;
                        next_range_warn  = (next_cfg.gain < gpa_pkg::GAIN_MIN)
                                        || (next_cfg.gain > gpa_pkg::GAIN_MAX);
                    end
                end
                gpa_pkg::IDX_FINE: begin
                    if (w_strb[1] && w_strb[0]) begin
                        next_cfg.fine_phase = w_data[ADJ_W-1+gpa_pkg::ADJ_LSB:gpa_pkg::ADJ_LSB];
                    end
                end
                gpa_pkg::IDX_COARSE: begin
                    if (w_strb[1]) begin
                        next_cfg.phase_adjust_enable    = w_data[gpa_pkg::ENABLE_BIT];
                        next_cfg.coarse_phase_magnitude = w_data[gpa_pkg::MAGNITUDE_LSB +: 4];
                        next_cfg.low_freq_sample_clock  = w_data[gpa_pkg::LOW_FREQ_BIT];
                    end
                end
                gpa_pkg::IDX_TRIM: begin
                    if (w_strb[1]) begin
                        next_cfg.termination_trim_disable = w_data[gpa_pkg::TRIM_DIS_BIT];
                    end
                end
                default: begin
                end
            endcase
        end
        // Response handshake reopens the write channel
        if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid  = 1'b0;
            next_awready = 1'b1;
            next_wready  = 1'b1;
        end
        // Read: one outstanding at a time
        if (s_axi_arvalid && s_axi_arready) begin
            next_arready = 1'b0;
            next_rvalid  = 1'b1;
            next_rdata   = read_word(word_idx(s_axi_araddr), cfg, range_warn);
            next_rresp   = mapped(word_idx(s_axi_araddr)) ? gpa_pkg::RESP_OKAY : gpa_pkg::RESP_SLVERR;
        end
        if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid  = 1'b0;
            next_arready = 1'b1;
        end
    end

    // Register stage; reset gives power-on values
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg.gain                     <= gpa_pkg::GAIN_RST;
            cfg.fine_phase               <= gpa_pkg::FINE_RST;
            cfg.phase_adjust_enable      <= 1'b0;
            cfg.coarse_phase_magnitude   <= gpa_pkg::MAGNITUDE_RST;
            cfg.low_freq_sample_clock    <= 1'b0;
            cfg.termination_trim_disable <= 1'b0;
            gain_update   <= 1'b0;
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            aw_idx        <= 4'h0;
            w_data        <= 32'h0000_0000;
            w_strb        <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= gpa_pkg::RESP_OKAY;
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rresp   <= gpa_pkg::RESP_OKAY;
            s_axi_rdata   <= 32'h0000_0000;
            range_warn    <= 1'b0;
        end else if (clk_en) begin
            cfg           <= next_cfg;
            gain_update   <= next_gain_update;
            aw_held       <= next_aw_held;
            w_held        <= next_w_held;
            aw_idx        <= next_aw_idx;
            w_data        <= next_w_data;
            w_strb        <= next_w_strb;
            s_axi_awready <= next_awready;
            s_axi_wready  <= next_wready;
            s_axi_bvalid  <= next_bvalid;
            s_axi_bresp   <= next_bresp;
            s_axi_arready <= next_arready;
            s_axi_rvalid  <= next_rvalid;
            s_axi_rresp   <= next_rresp;
            s_axi_rdata   <= next_rdata;
            range_warn    <= next_range_warn;
        end
    end

    // Helper terms shared by the checks below
    logic               write_commit;  // Both halves held, answer not out yet
    logic               read_take;     // Read address taken on this edge
    assign write_commit = clk_en && aw_held && w_held && !s_axi_bvalid;
    assign read_take    = clk_en && s_axi_arvalid && s_axi_arready;

    // Gain write reaches the core next cycle with no calibration step
    sequence s_gain_write;
        write_commit && aw_idx == gpa_pkg::IDX_GAIN && w_strb[1:0] == 2'h3;
    endsequence
    a_gain_applies: assert property (@(posedge aclk) disable iff (!aresetn)
        s_gain_write |=> gain_update && cfg.gain == $past(w_data[gpa_pkg::ADJ_LSB +: ADJ_W]))
        else $error("Gain write not applied");
    // Strobe lasts a single enabled cycle
    a_update_pulse: assert property (@(posedge aclk) disable iff (!aresetn)
        clk_en && gain_update |=> !gain_update)
        else $error("Gain update pulse too long");
    // Only a gain write moves the gain, so no calibration step touches it
    a_gain_held: assert property (@(posedge aclk) disable iff (!aresetn)
        !(write_commit && aw_idx == gpa_pkg::IDX_GAIN) |=> $stable(cfg.gain))
        else $error("Gain changed without a write");

    // Fine value lands one edge after its commit
    sequence s_fine_write;
        write_commit && aw_idx == gpa_pkg::IDX_FINE && w_strb[1:0] == 2'h3;
    endsequence
    a_fine_write: assert property (@(posedge aclk) disable iff (!aresetn)
        s_fine_write |=> cfg.fine_phase == $past(w_data[gpa_pkg::ADJ_LSB +: ADJ_W]))
        else $error("Fine phase write not applied");

    // Power-on value of the phase adjust enable bit
    a_enable_reset: assert property (@(posedge aclk)
        $rose(aresetn) |-> !cfg.phase_adjust_enable)
        else $error("Phase enable not off after reset");
    // Coarse write with the upper lane enabled
    sequence s_coarse_write;
        write_commit && aw_idx == gpa_pkg::IDX_COARSE && w_strb[1];
    endsequence
    a_coarse_write: assert property (@(posedge aclk) disable iff (!aresetn)
        s_coarse_write |=> cfg.coarse_phase_magnitude == $past(w_data[gpa_pkg::MAGNITUDE_LSB +: 4])
            && cfg.phase_adjust_enable == $past(w_data[gpa_pkg::ENABLE_BIT]))
        else $error("Coarse magnitude not stored");
    a_low_freq_write: assert property (@(posedge aclk) disable iff (!aresetn)
        s_coarse_write |=> cfg.low_freq_sample_clock == $past(w_data[gpa_pkg::LOW_FREQ_BIT]))
        else $error("Low frequency option not stored");
    // Coarse fields hold between coarse writes
    a_coarse_held: assert property (@(posedge aclk) disable iff (!aresetn)
        !(write_commit && aw_idx == gpa_pkg::IDX_COARSE) |=> $stable(cfg.coarse_phase_magnitude)
            && $stable(cfg.phase_adjust_enable) && $stable(cfg.low_freq_sample_clock))
        else $error("Coarse field changed without a write");

    // Trim disable: off after reset, then follows its word
    a_trim_reset: assert property (@(posedge aclk)
        $rose(aresetn) |-> !cfg.termination_trim_disable && cfg.coarse_phase_magnitude == 4'h0)
        else $error("Trim or magnitude not at reset value");
    sequence s_trim_write;
        write_commit && aw_idx == gpa_pkg::IDX_TRIM && w_strb[1];
    endsequence
    a_trim_write: assert property (@(posedge aclk) disable iff (!aresetn)
        s_trim_write |=> cfg.termination_trim_disable == $past(w_data[gpa_pkg::TRIM_DIS_BIT]))
        else $error("Trim disable write not stored");

    // Write answer: raised next edge with both channels closed, held until taken
    sequence s_write_answer;
        s_axi_bvalid && !s_axi_awready && !s_axi_wready;
    endsequence
    a_write_answer: assert property (@(posedge aclk) disable iff (!aresetn)
        write_commit |=> s_write_answer)
        else $error("Write not answered next cycle");
    a_bvalid_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("Write response dropped early");
    // Unmapped write refused, settings untouched
    a_write_refused: assert property (@(posedge aclk) disable iff (!aresetn)
        write_commit && !mapped(aw_idx) |=> s_axi_bresp == gpa_pkg::RESP_SLVERR && $stable(cfg))
        else $error("Unmapped write not refused");

    // Read answered next edge and held until taken
    a_read_answer: assert property (@(posedge aclk) disable iff (!aresetn)
        read_take |=> s_axi_rvalid && !s_axi_arready)
        else $error("Read not answered next cycle");
    a_rvalid_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("Read data changed while waiting");
    // Unmapped read gives zero with an error code
    a_read_refused: assert property (@(posedge aclk) disable iff (!aresetn)
        read_take && !mapped(word_idx(s_axi_araddr)) |=> s_axi_rresp == gpa_pkg::RESP_SLVERR
            && s_axi_rdata == 32'h0000_0000)
        else $error("Unmapped read not refused");

    // Enable low freezes settings and both answers
    a_freeze_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        !clk_en |=> $stable(cfg) && $stable(s_axi_bvalid) && $stable(s_axi_rvalid))
        else $error("State moved while clock enable low");
endmodule : gpa_regs
`default_nettype wire

// *** shared/gpa_pkg.sv ***
// Package: register map, field layout and reset values of the gain and phase adjust bank
package gpa_pkg;
    // Register indices as printed; byte address is four times the index
    localparam logic [3:0]  IDX_GAIN        = 4'h3;
    localparam logic [3:0]  IDX_FINE        = 4'hd;
    localparam logic [3:0]  IDX_COARSE      = 4'he;
    localparam logic [3:0]  IDX_TRIM        = 4'h1;   // Holder of the termination trim disable bit
    localparam logic [3:0]  IDX_STATUS      = 4'h8;   // Status word of this block
    // Field positions
    localparam int          ADJ_LSB         = 7;      // Gain and fine value sit in bits 15:7
    localparam int          ENABLE_BIT      = 15;
    localparam int          MAGNITUDE_LSB   = 11;
    localparam int          LOW_FREQ_BIT    = 10;
    localparam int          TRIM_DIS_BIT    = 13;
    // Reset values
    localparam logic [8:0]  GAIN_RST        = 9'h100; // 1000 0000 0b, nominal range
    localparam logic [8:0]  FINE_RST        = 9'h000;
    localparam logic [3:0]  MAGNITUDE_RST   = 4'h0;
    localparam logic [8:0]  GAIN_MIN        = 9'h0c0; // Advised lower bound
    localparam logic [8:0]  GAIN_MAX        = 9'h1c0; // Advised upper bound
    localparam int          STEP_PS         = 70;     // Coarse step size, picoseconds
    // AXI responses
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;

    // Settings driven into the converter core
    typedef struct packed {
        logic [8:0] gain;             // Full-scale gain adjust
        logic [8:0] fine_phase;       // Fine sample clock phase
        logic       phase_adjust_enable;
        logic [3:0] coarse_phase_magnitude;
        logic       low_freq_sample_clock;
        logic       termination_trim_disable;
    } gpa_cfg_t;

    typedef enum logic [1:0] {
        GPA_IDLE = 2'b00,
        GPA_WRESP = 2'b01,
        GPA_RRESP = 2'b10
    } gpa_state_t;
endpackage : gpa_pkg

// *** tb/gpa_regs_tb_top.sv ***
// Self-checking bench for the gain and phase adjust register bank
`timescale 1ns/100ps
`default_nettype none
module gpa_regs_tb_top;
    logic              aclk;           // 200 MHz clock
    logic              aresetn;        // Sync reset, active low
    logic              clk_en;         // High except in the freeze scenario
    logic [5:0]        s_axi_awaddr;
    logic              s_axi_awvalid;
    logic              s_axi_awready;
    logic [31:0]       s_axi_wdata;
    logic [3:0]        s_axi_wstrb;
    logic              s_axi_wvalid;
    logic              s_axi_wready;
    logic [1:0]        s_axi_bresp;
    logic              s_axi_bvalid;
    logic              s_axi_bready;
    logic [5:0]        s_axi_araddr;
    logic              s_axi_arvalid;
    logic              s_axi_arready;
    logic [31:0]       s_axi_rdata;
    logic [1:0]        s_axi_rresp;
    logic              s_axi_rvalid;
    logic              s_axi_rready;
    gpa_pkg::gpa_cfg_t cfg;            // Live settings seen by the core
    gpa_pkg::gpa_cfg_t exp_cfg;        // Bench's own idea of those settings
    logic              gain_update;
    int                errors;         // Mismatch count
    int                tests_run;      // Comparison count
    int                cycles;         // Hang guard
    logic [1:0]        resp;
    logic              upd;
    logic [31:0]       rd;

    gpa_regs u_gpa_regs (.aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .cfg(cfg), .gain_update(gain_update));

    // Free-running clock, 5 ns period
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end

    // Hang guard: the whole run needs far fewer cycles than this
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            errors++;
            give_verdict();
        end
    end

    // One compare for every value kind, widened to a word
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    // Write: address and data offered together, each dropped once taken
    task automatic axi_write(input logic [5:0] a, input logic [31:0] d, output logic [1:0] r, output logic u);
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata   <= d;
        s_axi_wstrb   <= 4'hf;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        forever begin
            @(posedge aclk);
            // A transfer also needs the enable high, as the block freezes its handshakes
            if (clk_en && s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (clk_en && s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (clk_en && s_axi_bvalid) begin
                r = s_axi_bresp;
                u = gain_update;
                s_axi_bready <= 1'b0;
                break;
            end
        end
    endtask : axi_write

    // Read: address held until taken, rready until data seen
    task automatic axi_read(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        forever begin
            @(posedge aclk);
            if (clk_en && s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (clk_en && s_axi_rvalid) begin
                d = s_axi_rdata;
                r = s_axi_rresp;
                s_axi_rready <= 1'b0;
                break;
            end
        end
    endtask : axi_read

    // Power-on contents of every register and of the live settings
    task automatic t_reset();
        axi_read({gpa_pkg::IDX_GAIN, 2'b00}, rd, resp);
        check({16'h0, rd[15:0]}, {16'h0, gpa_pkg::GAIN_RST, 7'h7f});
        axi_read({gpa_pkg::IDX_FINE, 2'b00}, rd, resp);
        check({16'h0, rd[15:0]}, 32'h0000007f);
        axi_read({gpa_pkg::IDX_COARSE, 2'b00}, rd, resp);
        check({16'h0, rd[15:0]}, 32'h000003ff);
        axi_read({gpa_pkg::IDX_TRIM, 2'b00}, rd, resp);
        check({31'h0, rd[gpa_pkg::TRIM_DIS_BIT]}, 32'h0);
        check({7'h0, cfg}, {7'h0, exp_cfg});
        axi_read({gpa_pkg::IDX_STATUS, 2'b00}, rd, resp);
        check({30'h0, resp}, {30'h0, gpa_pkg::RESP_OKAY});
        check(rd, 32'h0);
    endtask : t_reset

    // Gain writes at both advised bounds, each read back, ones in the unused low bits
    task automatic t_gain();
        logic [8:0] vals [2];
        vals[0] = gpa_pkg::GAIN_MIN;
        vals[1] = gpa_pkg::GAIN_MAX;
        foreach (vals[i]) begin
            axi_write({gpa_pkg::IDX_GAIN, 2'b00}, {16'h0, vals[i], 7'h7f}, resp, upd);
            exp_cfg.gain = vals[i];
            check({30'h0, resp}, {30'h0, gpa_pkg::RESP_OKAY});
            check({31'h0, upd}, 32'h1);
            check({7'h0, cfg}, {7'h0, exp_cfg});
            axi_read({gpa_pkg::IDX_GAIN, 2'b00}, rd, resp);
            check({16'h0, rd[15:0]}, {16'h0, vals[i], 7'h7f});
        end
        axi_write({gpa_pkg::IDX_FINE, 2'b00}, 32'h0000aaff, resp, upd);
        exp_cfg.fine_phase = 9'h155;
        check({31'h0, upd}, 32'h0);
        check({7'h0, cfg}, {7'h0, exp_cfg});
    endtask : t_gain

    // Enable with trim disable set alongside, even magnitude, low-frequency option
    task automatic t_coarse();
        axi_write({gpa_pkg::IDX_TRIM, 2'b00}, 32'h0000ffff, resp, upd);
        axi_write({gpa_pkg::IDX_COARSE, 2'b00}, 32'h0000d7ff, resp, upd);
        check({30'h0, resp}, {30'h0, gpa_pkg::RESP_OKAY});
        exp_cfg.termination_trim_disable = 1'b1;
        exp_cfg.phase_adjust_enable = 1'b1;
        exp_cfg.coarse_phase_magnitude = 4'ha;
        exp_cfg.low_freq_sample_clock = 1'b1;
        check({7'h0, cfg}, {7'h0, exp_cfg});
        axi_read({gpa_pkg::IDX_COARSE, 2'b00}, rd, resp);
        check({16'h0, rd[15:0]}, 32'h0000d7ff);
        axi_read({gpa_pkg::IDX_TRIM, 2'b00}, rd, resp);
        check({31'h0, rd[gpa_pkg::TRIM_DIS_BIT]}, 32'h1);
        axi_read({gpa_pkg::IDX_STATUS, 2'b00}, rd, resp);
        check(rd, 32'h0);
    endtask : t_coarse

    // Unmapped word: refused both ways, settings untouched
    task automatic t_unmapped();
        axi_write(6'h3c, 32'h0000ffff, resp, upd);
        check({30'h0, resp}, {30'h0, gpa_pkg::RESP_SLVERR});
        axi_read(6'h3c, rd, resp);
        check({30'h0, resp}, {30'h0, gpa_pkg::RESP_SLVERR});
        check(rd, 32'h0);
        check({7'h0, cfg}, {7'h0, exp_cfg});
    endtask : t_unmapped

    // Enable low: a pending gain write waits, then completes once released
    task automatic t_freeze();
        @(posedge aclk);
        clk_en <= 1'b0;
        fork
            axi_write({gpa_pkg::IDX_GAIN, 2'b00}, {16'h0, gpa_pkg::GAIN_RST, 7'h7f}, resp, upd);
            begin
                repeat (4) @(posedge aclk);
                check({7'h0, cfg}, {7'h0, exp_cfg});
                check({31'h0, s_axi_bvalid}, 32'h0);
                clk_en <= 1'b1;
            end
        join
        exp_cfg.gain = gpa_pkg::GAIN_RST;
        check({30'h0, resp}, {30'h0, gpa_pkg::RESP_OKAY});
        check({31'h0, upd}, 32'h1);
        check({7'h0, cfg}, {7'h0, exp_cfg});
    endtask : t_freeze

    // Single exit of the run
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : give_verdict

    // Main sequence: reset for six cycles, then the scenarios
    initial begin
        errors = 0;
        tests_run = 0;
        cycles = 0;
        aresetn = 1'b0;
        clk_en = 1'b1;
        s_axi_awaddr = 6'h0;
        s_axi_awvalid = 1'b0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'h0;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b0;
        s_axi_araddr = 6'h0;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0;
        exp_cfg = '0;
        exp_cfg.gain = gpa_pkg::GAIN_RST;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_gain();
        t_coarse();
        t_unmapped();
        t_freeze();
        give_verdict();
    end
endmodule : gpa_regs_tb_top
`default_nettype wire
